// ==== logic/measurement_command_sequencer.sv ====
// Command sequencer: holds, releases and executes instrument commands.
// Assumes commands arrive as register writes and the engine reports meas_done.
`timescale 1ns/1ps
`include "seq_map.svh"

module measurement_command_sequencer (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [31:0]          rdata,
  input  wire logic [31:0]          reading_in,
  input  wire logic                 reading_valid,
  input  wire logic                 meas_done,
  input  wire logic                 rom_sum_ok,
  input  wire logic                 talk_addr,
  output logic                      meas_start,
  output logic                      bus_trig,
  output logic                      meas_abort,
  output seq_pkg::setup_t           setup_out
);

  seq_pkg::st_t st_r;
  seq_pkg::st_t st_nxt;
  seq_pkg::cmd_t new_cmd;
  logic          cmd_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Command classes

  // Commands that act even inside the trigger model
  function automatic logic urgent(input logic [4:0] code);
    urgent = (code == `C_RST) || (code == `C_PRESET) || (code == `C_DCL) ||
             (code == `C_TRG) || (code == `C_ABORT);
  endfunction

  // Configure body, shared by configure and measure
  function automatic seq_pkg::st_t do_conf(input seq_pkg::st_t s_in,
                                           input logic [3:0] arg);
    seq_pkg::st_t s;
    s = s_in;
    if (arg != `ARG_NOFUNC) begin
      s.setup.func = arg[1:0];
    end
    // Sources immediate, counts one, delay zero, math and buffer off, autozero on
    s.setup[`SETUP_HI-2:0] = `CONF_BASE;
    if (s_in.setup.buf_en) begin
      s.abort = 1'b1;
    end
    s.ph = seq_pkg::PH_IDLE;
    do_conf = s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Execution of one command

  function automatic seq_pkg::st_t exec(input seq_pkg::st_t s_in,
                                        input seq_pkg::cmd_t c,
                                        input logic rom_ok);
    seq_pkg::st_t s;
    logic [1:0]   k;
    s = s_in;
    k = c.arg[1:0];
    case (c.code)
      `C_OPC: begin
        s.opc = 1'b1;
      end
      `C_OPCQ: begin
        s.outq = `ASCII_1;
        s.outv = 1'b1;
      end
      `C_INIT: begin
        if (s.ph == seq_pkg::PH_IDLE) begin
          s.ph    = seq_pkg::PH_RUN;
          s.start = 1'b1;
        end
      end
      `C_SAV: begin
        if (c.arg <= `SLOT_MAX) begin
          s.slot[k] = s.setup;
          s.par[k]  = ^s.setup;
        end else begin
          s.err = 1'b1;
        end
      end
      `C_RCL: begin
        if (c.arg > `SLOT_MAX) begin
          s.err = 1'b1;
        end else if (^s.slot[k] != s.par[k]) begin
          // Damaged image: slot and setup fall back to preset
          s.slot[k] = `PRESET_SETUP;
          s.par[k]  = ^`PRESET_SETUP;
          s.setup   = `PRESET_SETUP;
          s.err     = 1'b1;
        end else begin
          s.setup = s.slot[k];
        end
      end
      `C_RST: begin
        s.setup      = `RST_SETUP;
        s.cnt        = 4'h0;
        s.fetch_owed = 1'b0;
        if (s.ph == seq_pkg::PH_RUN) begin
          s.abort = 1'b1;
        end
        s.ph = seq_pkg::PH_IDLE;
      end
      `C_PRESET: begin
        s.setup = `PRESET_SETUP;
      end
      `C_TRG: begin
        if (s.setup.arm_src == `SRC_BUS && s.ph == seq_pkg::PH_RUN) begin
          s.trig = 1'b1;
        end
      end
      `C_TST: begin
        s.outq = rom_ok ? `ASCII_0 : `ASCII_1;
        s.outv = 1'b1;
      end
      `C_WAI: begin
        s.err = s_in.err;
      end
      `C_CONF: begin
        s = do_conf(s, c.arg);
      end
      `C_FETCH: begin
        s.outq = s.latest;
        s.outv = 1'b1;
      end
      `C_READ: begin
        s.ph         = seq_pkg::PH_RUN;
        s.start      = 1'b1;
        s.fetch_owed = 1'b1;
      end
      `C_MEAS: begin
        s            = do_conf(s, c.arg);
        s.ph         = seq_pkg::PH_RUN;
        s.start      = 1'b1;
        s.fetch_owed = 1'b1;
      end
      `C_ABORT: begin
        if (s.ph == seq_pkg::PH_RUN) begin
          s.abort = 1'b1;
        end
        s.ph         = seq_pkg::PH_IDLE;
        s.fetch_owed = 1'b0;
      end
      `C_DCL: begin
        s.cnt  = 4'h0;
        s.outv = 1'b0;
      end
      default: begin
        s.err = 1'b1;
      end
    endcase
    exec = s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  assign new_cmd.code = wdata[`CMD_CODE_HI:`CMD_CODE_LO];
  assign new_cmd.arg  = wdata[`CMD_ARG_HI:`CMD_ARG_LO];
  assign cmd_wr       = wr && (addr == `A_CMD);

  // Bus, completion, release of held commands, then the new command
  always_comb begin
    st_nxt       = st_r;
    st_nxt.start = 1'b0;
    st_nxt.trig  = 1'b0;
    st_nxt.abort = 1'b0;
    st_nxt.rdata = 32'h0000_0000;

    // Register writes other than commands
    if (wr && addr == `A_STATUS) begin
      if (wdata[`ST_OPC_B]) begin
        st_nxt.opc = 1'b0;
      end
      if (wdata[`ST_OVF_B]) begin
        st_nxt.ovf = 1'b0;
      end
      if (wdata[`ST_ERR_B]) begin
        st_nxt.err = 1'b0;
      end
    end
    if (wr && addr == `A_SETUP) begin
      st_nxt.setup = wdata[`SETUP_HI:0];
    end

    // Register reads; answers leave only while addressed to talk
    if (rd) begin
      case (addr)
        `A_STATUS: begin
          st_nxt.rdata[`ST_IDLE_B]            = (st_r.ph == seq_pkg::PH_IDLE);
          st_nxt.rdata[`ST_OPC_B]             = st_r.opc;
          st_nxt.rdata[`ST_OUTV_B]            = st_r.outv;
          st_nxt.rdata[`ST_OVF_B]             = st_r.ovf;
          st_nxt.rdata[`ST_ERR_B]             = st_r.err;
          st_nxt.rdata[`ST_CNT_HI:`ST_CNT_LO] = st_r.cnt;
        end
        `A_OUTQ: begin
          if (talk_addr) begin
            st_nxt.rdata = st_r.outq;
            st_nxt.outv  = 1'b0;
          end
        end
        `A_SETUP: begin
          st_nxt.rdata[`SETUP_HI:0] = st_r.setup;
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Newest reading from the engine
    if (reading_valid) begin
      st_nxt.latest = reading_in;
    end

    // End of the programmed measurements
    if (st_r.ph == seq_pkg::PH_RUN && meas_done) begin
      st_nxt.ph = seq_pkg::PH_IDLE;
      if (st_r.fetch_owed) begin
        st_nxt.outq       = reading_valid ? reading_in : st_r.latest;
        st_nxt.outv       = 1'b1;
        st_nxt.fetch_owed = 1'b0;
      end
    end

    // One held command per cycle while idle, oldest first
    if (st_r.ph == seq_pkg::PH_IDLE && st_r.cnt != 4'h0) begin
      for (int i = 0; i < `QDEPTH - 1; i++) begin
        st_nxt.q[i] = st_r.q[i+1];
      end
      st_nxt.cnt = st_r.cnt - 4'h1;
      st_nxt     = exec(st_nxt, st_r.q[0], rom_sum_ok);
    end

    // New command: urgent ones act now, others wait their turn
    if (cmd_wr) begin
      if (urgent(new_cmd.code)) begin
        st_nxt = exec(st_nxt, new_cmd, rom_sum_ok);
      end else if (st_r.ph == seq_pkg::PH_IDLE && st_r.cnt == 4'h0) begin
        st_nxt = exec(st_nxt, new_cmd, rom_sum_ok);
      end else if (st_nxt.cnt < `QFULL) begin
        st_nxt.q[st_nxt.cnt[2:0]] = new_cmd;
        st_nxt.cnt                = st_nxt.cnt + 4'h1;
      end else begin
        st_nxt.ovf = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Slots start with preset defaults
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r            <= '0;
      st_r.ph         <= seq_pkg::PH_IDLE;
      st_r.setup      <= `RST_SETUP;
      st_r.slot       <= {`SLOTS{`PRESET_SETUP}};
      st_r.par        <= {`SLOTS{^`PRESET_SETUP}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign rdata      = st_r.rdata;
  assign meas_start = st_r.start;
  assign bus_trig   = st_r.trig;
  assign meas_abort = st_r.abort;
  assign setup_out  = st_r.setup;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic quiet_idle;
  assign quiet_idle = (st_r.ph == seq_pkg::PH_IDLE) && (st_r.cnt == 4'h0);

  opc_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_OPC && quiet_idle |=> st_r.opc)
    else $error("operation-complete bit not set");

  opc_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_OPCQ && quiet_idle |=> st_r.outv && st_r.outq == `ASCII_1)
    else $error("operation-complete answer missing");

  hold_run_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_CONF && st_r.ph == seq_pkg::PH_RUN && st_r.cnt < `QFULL
    |=> st_r.cnt == $past(st_r.cnt) + 4'h1 && st_r.start == 1'b0)
    else $error("command ran while measuring");

  release_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_r.ph == seq_pkg::PH_IDLE && st_r.cnt != 4'h0 && !wr |=> st_r.cnt == $past(st_r.cnt) - 4'h1)
    else $error("held command not released");

  init_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_INIT && quiet_idle |=> st_r.ph == seq_pkg::PH_RUN && meas_start
    ##1 !meas_start)
    else $error("initiate did not start");

  rst_flush_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_RST
    |=> st_r.cnt == 4'h0 && st_r.setup == `RST_SETUP && !st_r.fetch_owed)
    else $error("reset left work pending");

  bus_trig_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_TRG && st_r.ph == seq_pkg::PH_RUN && !meas_done
    |=> bus_trig == $past(st_r.setup.arm_src == `SRC_BUS))
    else $error("bus trigger wrong");

  self_test_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_TST && quiet_idle
    |=> st_r.outq == ($past(rom_sum_ok) ? `ASCII_0 : `ASCII_1))
    else $error("self-test answer wrong");

  conf_setup_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_CONF && quiet_idle && !(wr && addr == `A_SETUP)
    |=> st_r.setup[`SETUP_HI-2:0] == `CONF_BASE && st_r.ph == seq_pkg::PH_IDLE)
    else $error("configure setup wrong");

  talk_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd && addr == `A_OUTQ && !talk_addr && quiet_idle
    |=> rdata == 32'h0000_0000 && $stable(st_r.outq) && $stable(st_r.outv))
    else $error("answer sent while not talker");

  abort_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_ABORT && st_r.ph == seq_pkg::PH_RUN && !meas_done
    |=> st_r.ph == seq_pkg::PH_IDLE && meas_abort)
    else $error("abort did not return to idle");

  // Query answers and one-shot commands
  fetch_latest_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_FETCH && quiet_idle && !reading_valid
    |=> st_r.outv && st_r.outq == $past(st_r.latest)
        && st_r.setup == $past(st_r.setup) && !meas_start)
    else $error("fetch answer wrong");

  read_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_READ && quiet_idle
    |=> meas_start && st_r.ph == seq_pkg::PH_RUN && st_r.fetch_owed)
    else $error("read did not start");

  read_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_r.ph == seq_pkg::PH_RUN && meas_done && reading_valid && st_r.fetch_owed && !cmd_wr
    |=> st_r.outv && st_r.outq == $past(reading_in) && st_r.ph == seq_pkg::PH_IDLE)
    else $error("read answer wrong");

  meas_conf_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_MEAS && new_cmd.arg == `ARG_NOFUNC && quiet_idle
    |=> st_r.setup.func == $past(st_r.setup.func)
        && st_r.setup[`SETUP_HI-2:0] == `CONF_BASE && meas_start && st_r.fetch_owed)
    else $error("measure setup wrong");

  // Setup slots
  save_slot_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_SAV && new_cmd.arg == 4'h0 && quiet_idle
    |=> st_r.slot[0] == $past(st_r.setup) && st_r.par[0] == ^st_r.slot[0])
    else $error("setup not saved");

  setup_recall_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_RCL && new_cmd.arg == 4'h0 && quiet_idle
    && ^st_r.slot[0] == st_r.par[0]
    |=> st_r.setup == $past(st_r.slot[0]))
    else $error("setup not recalled");

  // Clears and no-ops
  clear_flush_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_DCL
    |=> st_r.cnt == 4'h0 && !st_r.outv)
    else $error("clear left work held");

  wait_noop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && new_cmd.code == `C_WAI && quiet_idle
    |=> st_r.setup == $past(st_r.setup) && st_r.outv == $past(st_r.outv)
        && st_r.err == $past(st_r.err) && !meas_start && quiet_idle)
    else $error("wait command had an effect");

endmodule

// ==== logic/seq_map.svh ====
// Constants of the measurement command sequencer: offsets, codes, fields, defaults.
// Assumes a single 250 MHz clock domain and a plain strobe register port.
//
// How it works
// - Operation-complete command sets the status bit once earlier work is done.
// - Operation-complete query places ASCII 1 in the output word after earlier work.
// - While measuring, ordinary commands are held; reset, preset, clears, triggers, abort act.
// - On return to idle, held commands run in arrival order, completion ones included.
// - Initiate leaves idle and starts the programmed measurements.
// - Three setup slots, 0 to 2: save stores the setup, recall restores it.
// - A saved image holds every control that reset touches: the whole setup word.
// - A recall of a damaged slot reloads that slot, and the setup, with preset defaults.
// - Reset restores defaults, flushes held commands, drops owed completion answers.
// - Trigger acts as group execute trigger, only with the arm source on bus.
// - Self-test query returns ROM checksum result: 0 for pass, 1 for fail.
// - Wait-to-continue does nothing, as no command overlaps a later one.
// - Configure runs at once when idle, otherwise waits for idle.
// - Configure: function, immediate sources, counts one, delay zero, idle, math off.
// - Fetch returns the latest reading without measuring or touching the setup.
// - Read is initiate then fetch, waiting for idle first.
// - Query answers leave only while the device is addressed to talk.
// - Measure is configure then read; no function named keeps the present one.
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

// Register byte offsets
`define A_CMD        8'h00
`define A_STATUS     8'h04
`define A_OUTQ       8'h08
`define A_SETUP      8'h0c

// Command word fields
`define CMD_CODE_HI  4
`define CMD_CODE_LO  0
`define CMD_ARG_HI   11
`define CMD_ARG_LO   8

// Status word fields, then the setup word's top bit
`define ST_IDLE_B    0
`define ST_OPC_B     1
`define ST_OUTV_B    2
`define ST_OVF_B     3
`define ST_ERR_B     4
`define ST_CNT_HI    11
`define ST_CNT_LO    8
`define SETUP_HI     30

// Command codes
`define C_OPC        5'h01
`define C_OPCQ       5'h02
`define C_INIT       5'h03
`define C_SAV        5'h04
`define C_RCL        5'h05
`define C_RST        5'h06
`define C_TRG        5'h07
`define C_TST        5'h08
`define C_WAI        5'h09
`define C_CONF       5'h0a
`define C_FETCH      5'h0b
`define C_READ       5'h0c
`define C_MEAS       5'h0d
`define C_ABORT      5'h0e
`define C_PRESET     5'h0f
`define C_DCL        5'h10

// Held command store, setup slots and the no-function argument
`define QDEPTH       8
`define QFULL        4'h8
`define SLOTS        3
`define SLOT_MAX     4'h2
`define ARG_NOFUNC   4'hf

// Setup values and answers
`define RST_SETUP    31'h0008_0801
`define PRESET_SETUP 31'h0008_0801
`define CONF_BASE    29'h0008_0801
`define SRC_BUS      1'b1
`define ASCII_0      32'h0000_0030
`define ASCII_1      32'h0000_0031

`endif

// ==== logic/seq_pkg.sv ====
// Types of the measurement command sequencer.
// Assumes seq_map.svh is on the include path.
`include "seq_map.svh"

package seq_pkg;

  typedef enum logic {PH_IDLE, PH_RUN} phase_t;

  typedef struct packed {
    logic [4:0] code;
    logic [3:0] arg;
  } cmd_t;

  typedef struct packed {
    logic [1:0] func;
    logic       arm_src;
    logic       trig_src;
    logic [7:0] arm_cnt;
    logic [7:0] trig_cnt;
    logic [7:0] delay;
    logic       math;
    logic       buf_en;
    logic       azero;
  } setup_t;

  typedef struct packed {
    phase_t                  ph;
    cmd_t   [`QDEPTH-1:0]    q;
    logic   [3:0]            cnt;
    setup_t                  setup;
    setup_t [`SLOTS-1:0]     slot;
    logic   [`SLOTS-1:0]     par;
    logic   [31:0]           latest;
    logic   [31:0]           outq;
    logic                    outv;
    logic                    opc;
    logic                    fetch_owed;
    logic                    ovf;
    logic                    err;
    logic                    start;
    logic                    trig;
    logic                    abort;
    logic   [31:0]           rdata;
  } st_t;

endpackage

// ==== test/engine_model.sv ====
// Model of the measurement engine that sits behind the sequencer.
// Assumes the sequencer's clock and reset; a run lasts LAT cycles.
`timescale 1ns/1ps

module engine_model #(
  parameter int LAT = 6
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        meas_start,
  input  wire logic        meas_abort,
  output logic      [31:0] reading_in,
  output logic             reading_valid,
  output logic             meas_done
);
  logic [7:0]  cnt_r;
  logic [31:0] num_r;

  ////////////////////////////////////////////////////////////////////////////
  // Run countdown; abort ends a run with no reading
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r         <= 8'h00;
      num_r         <= 32'h0000_1000;
      reading_in    <= 32'h0000_0000;
      reading_valid <= 1'b0;
      meas_done     <= 1'b0;
    end else begin
      reading_valid <= 1'b0;
      meas_done     <= 1'b0;
      reading_in    <= ~reading_in;  // Stale value never lingers
      if (meas_abort) begin
        cnt_r <= 8'h00;
      end else if (meas_start) begin
        cnt_r <= 8'(LAT);
      end else if (cnt_r == 8'h01) begin
        cnt_r         <= 8'h00;
        num_r         <= num_r + 32'h0000_0001;
        reading_in    <= num_r;
        reading_valid <= 1'b1;
        meas_done     <= 1'b1;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the measurement command sequencer.
// Assumes the engine model on the far side and the plain strobe register port.
`timescale 1ns/1ps
`include "seq_map.svh"

module tb_top;
  logic            sys_clk, rst_b, wr, rd, rom_sum_ok, talk_addr;
  logic [7:0]      addr;
  logic [31:0]     wdata, rdata, reading_in, last_rd, v;
  logic            reading_valid, meas_done, meas_start, bus_trig, meas_abort;
  seq_pkg::setup_t setup_out;
  int              num_errors, n_compared, n_start, n_trig, n_abort, s;

  measurement_command_sequencer i_measurement_command_sequencer (
    .sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .reading_in(reading_in), .reading_valid(reading_valid),
    .meas_done(meas_done), .rom_sum_ok(rom_sum_ok), .talk_addr(talk_addr),
    .meas_start(meas_start), .bus_trig(bus_trig), .meas_abort(meas_abort),
    .setup_out(setup_out));

  engine_model #(.LAT(16)) i_engine_model (
    .sys_clk(sys_clk), .rst_b(rst_b), .meas_start(meas_start), .meas_abort(meas_abort),
    .reading_in(reading_in), .reading_valid(reading_valid), .meas_done(meas_done));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and pulse counters
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Pulses counted mid-cycle, where they are settled
  always @(negedge sys_clk) begin
    n_start <= n_start + int'(meas_start === 1'b1);
    n_trig  <= n_trig + int'(bus_trig === 1'b1);
    n_abort <= n_abort + int'(meas_abort === 1'b1);
    if (reading_valid) last_rd <= reading_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks and compare
  task automatic test_done();
    if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e || ^e === 1'bx) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic cmd(input logic [4:0] c, input logic [3:0] a);
    wr_reg(`A_CMD, {16'h0000, 4'h0, a, 3'h0, c});
  endtask

  task automatic rd_raw(input logic [7:0] a);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string nm);
    rd_raw(a);
    chk(nm, e, v & m);
  endtask

  task automatic wait_idle();
    int i;
    v = 32'h0000_0000;
    for (i = 0; i < 40 && (v & 32'h0000_0f01) !== 32'h0000_0001; i++) rd_raw(`A_STATUS);
    chk("idle and empty", 32'h0000_0001, v & 32'h0000_0f01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd_chk(`A_SETUP, 32'hffff_ffff, {1'b0, `RST_SETUP}, "setup");
    rd_chk(`A_STATUS, 32'h0000_0f1f, 32'h0000_0001, "status");
    rd_chk(8'h10, 32'hffff_ffff, 32'h0000_0000, "unmapped");
  endtask

  task automatic t_opc_query();
    talk_addr <= 1'b0;
    cmd(`C_INIT, 4'h0);
    chk("starts", 32'h0000_0001, 32'(n_start));
    cmd(`C_OPCQ, 4'h0);
    cmd(`C_WAI, 4'h0);
    rd_chk(`A_STATUS, 32'h0000_0f05, 32'h0000_0200, "held");
    wait_idle();
    rd_chk(`A_OUTQ, 32'hffff_ffff, 32'h0000_0000, "untalked");
    talk_addr <= 1'b1;
    rd_chk(`A_OUTQ, 32'hffff_ffff, `ASCII_1, "opc answer");
  endtask

  task automatic t_opc_cmd();
    cmd(`C_INIT, 4'h0);
    cmd(`C_OPC, 4'h0);
    rd_chk(`A_STATUS, 32'h0000_0002, 32'h0000_0000, "opc early");
    wait_idle();
    rd_chk(`A_STATUS, 32'h0000_0002, 32'h0000_0002, "opc set");
    wr_reg(`A_STATUS, 32'h0000_0002);
  endtask

  task automatic t_rst_cancel();
    s = n_abort;
    cmd(`C_INIT, 4'h0);
    cmd(`C_OPCQ, 4'h0);
    cmd(`C_RST, 4'h0);
    chk("abort", 32'(s + 1), 32'(n_abort));
    wait_idle();
    rd_chk(`A_STATUS, 32'h0000_0f04, 32'h0000_0000, "dropped");
    chk("setup out", {1'b0, `RST_SETUP}, {1'b0, setup_out});
    cmd(`C_INIT, 4'h0);
    cmd(`C_OPCQ, 4'h0);
    cmd(`C_DCL, 4'h0);
    rd_chk(`A_STATUS, 32'h0000_0f01, 32'h0000_0000, "clear flush");
    wait_idle();
    rd_chk(`A_STATUS, 32'h0000_0004, 32'h0000_0000, "clear answer");
  endtask

  task automatic t_save_recall();
    for (int k = 0; k < 3; k++) begin
      cmd(`C_CONF, 4'(k + 1));
      cmd(`C_SAV, 4'(k));
    end
    cmd(`C_PRESET, 4'h0);
    rd_chk(`A_SETUP, 32'hffff_ffff, {1'b0, `PRESET_SETUP}, "preset");
    cmd(`C_RST, 4'h0);
    for (int k = 0; k < 3; k++) begin
      cmd(`C_RCL, 4'(k));
      rd_chk(`A_SETUP, 32'hffff_ffff, {1'b0, 2'(k + 1), `CONF_BASE}, "recall");
    end
    cmd(`C_SAV, 4'h3);
    rd_chk(`A_STATUS, 32'h0000_0010, 32'h0000_0010, "bad slot");
    wr_reg(`A_STATUS, 32'h0000_0010);
  endtask

  task automatic t_selftest();
    for (int k = 0; k < 2; k++) begin
      rom_sum_ok <= (k == 0);
      cmd(`C_TST, 4'h0);
      rd_chk(`A_OUTQ, 32'hffff_ffff, (k == 0) ? `ASCII_0 : `ASCII_1, "self test");
    end
    cmd(`C_WAI, 4'h0);
    rd_chk(`A_STATUS, 32'h0000_0f1f, 32'h0000_0001, "wait idle");
  endtask

  task automatic t_read_fetch();
    s = n_start;
    cmd(`C_READ, 4'h0);
    wait_idle();
    rd_chk(`A_OUTQ, 32'hffff_ffff, last_rd, "read");
    cmd(`C_FETCH, 4'h0);
    rd_chk(`A_OUTQ, 32'hffff_ffff, last_rd, "fetch");
    chk("fetch runs", 32'(s + 1), 32'(n_start));
    cmd(`C_MEAS, `ARG_NOFUNC);
    wait_idle();
    rd_chk(`A_OUTQ, 32'hffff_ffff, last_rd, "measure");
    rd_chk(`A_SETUP, 32'hffff_ffff, {1'b0, 2'h3, `CONF_BASE}, "measure fn");
  endtask

  task automatic t_abort();
    s = n_abort;
    cmd(`C_INIT, 4'h0);
    cmd(`C_TRG, 4'h0);
    chk("trig", 32'h0000_0000, 32'(n_trig));
    wr_reg(`A_SETUP, {1'b0, `RST_SETUP} | 32'h1000_0000);
    cmd(`C_TRG, 4'h0);
    chk("bus trig", 32'h0000_0001, 32'(n_trig));
    cmd(`C_CONF, 4'h1);
    rd_chk(`A_STATUS, 32'h0000_0f01, 32'h0000_0100, "conf held");
    cmd(`C_ABORT, 4'h0);
    chk("abort pulse", 32'(s + 1), 32'(n_abort));
    wait_idle();
    rd_chk(`A_SETUP, 32'hffff_ffff, {1'b0, 2'h1, `CONF_BASE}, "conf");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    rst_b <= 1'b0;
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= 8'h00;
    wdata <= 32'h0000_0000;
    rom_sum_ok <= 1'b1;
    talk_addr <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_opc_query();
    t_opc_cmd();
    t_rst_cancel();
    t_save_recall();
    t_selftest();
    t_read_fetch();
    t_abort();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    test_done();
  end
endmodule
